/* File: hdl/interrupt_exception_prioritizer.sv */
// Interrupt and exception prioritizer of the processor core.
// Assumes the core pulses instr_boundary once per instruction boundary
// and drives its check inputs in that cycle on pclk.
`timescale 1ns/1ps
module interrupt_exception_prioritizer
  import exc_prio_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External request pins
  input wire logic nmi_request,
  input wire logic maskable_irq_request,
  // Interrupt acknowledge
  output logic inta_req,
  input wire logic ack_valid,
  input wire logic [7:0] ack_vector,
  // Core boundary and debug checks
  input wire logic instr_boundary,
  input wire logic interrupt_return_instr,
  input wire logic dbg_trap,
  input wire logic dbg_exec_break,
  // Fetch and decode checks
  input wire logic fetch_seg_fault,
  input wire logic fetch_seg_not_present,
  input wire logic fetch_page_fault,
  input wire logic illegal_opcode,
  input wire logic prot_only_opcode,
  input wire logic [4:0] instr_len,
  input wire logic priv_violation,
  // Coprocessor checks
  input wire logic wait_opcode,
  input wire logic fpu_opcode,
  input wire logic fpu_error,
  // Memory reference checks
  input wire logic mem_seg_fault,
  input wire logic mem_seg_not_present,
  input wire logic mem_seg_stack,
  input wire logic mem_page_fault,
  // Execution exceptions and software interrupts
  input wire logic exec_exc_valid,
  input wire logic [7:0] exec_exc_vector,
  input wire logic exec_soft_int,
  input wire logic task_state_segment_partial,
  // Delivery tracking
  input wire logic nested_fault,
  input wire logic [7:0] nested_vector,
  input wire logic delivery_done,
  // Selected exception
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output exc_class_t exc_class,
  output logic exc_restartable
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic {ST_RUN, ST_ACK_WAIT} ack_state_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic nmi_pending;
    logic nmi_in_service;
    ack_state_t state;
    logic deliver_busy;
    logic [7:0] deliver_vec;
    exc_out_t out;
    logic [31:0] prdata;
  } state_t;

  state_t s;
  state_t next_s;
  logic nmi_edge;
  logic irq_sync;
  logic cand_valid;
  logic [7:0] cand_vec;
  logic cand_dbg_fault;
  logic cand_trap_src;
  exc_class_t cand_cls;
  logic apb_hit;
  logic [31:0] rd_word;
  logic nested_now;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  ext_req_sampler u_sampler (
    .pclk(pclk),
    .presetn(presetn),
    .nmi_request(nmi_request),
    .maskable_irq_request(maskable_irq_request),
    .nmi_edge(nmi_edge),
    .irq_sync(irq_sync)
  );

  vector_classifier u_classifier (
    .vector(cand_vec),
    .debug_fault(cand_dbg_fault),
    .trap_source(cand_trap_src),
    .cls(cand_cls)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apb_hit = (paddr == CTRL_OFS) || (paddr == STATUS_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~apb_hit;
  assign prdata = s.prdata;
  assign nested_now = nested_fault & s.deliver_busy;

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (paddr == CTRL_OFS) begin
      rd_word[$bits(ctrl_t)-1:0] = s.ctrl;
    end else if (paddr == STATUS_OFS) begin
      rd_word[STAT_VEC_LSB +: 8] = s.out.vector;
      rd_word[STAT_CLS_LSB +: 2] = s.out.cls;
      rd_word[STAT_RST_BIT] = s.out.restartable;
      rd_word[STAT_NMIP_BIT] = s.nmi_pending;
      rd_word[STAT_NMIS_BIT] = s.nmi_in_service;
      rd_word[STAT_ACK_BIT] = (s.state == ST_ACK_WAIT);
      rd_word[STAT_BUSY_BIT] = s.deliver_busy;
    end
  end

  // ----------------------------------------------------------------
  // Candidate selection: fixed-order priority encoder
  // ----------------------------------------------------------------
  always_comb begin
    cand_valid = 1'b0;
    cand_vec = VEC_DIVIDE;
    cand_dbg_fault = 1'b0;
    cand_trap_src = 1'b0;
    unique case (s.state)
      ST_ACK_WAIT: begin
        if (ack_valid) begin
          cand_valid = 1'b1;
          cand_vec = ack_vector;
          cand_trap_src = 1'b1;
        end
      end
      ST_RUN: begin
        if (nested_now) begin
          cand_valid = 1'b1;
          cand_vec = nested_vector;
          if ((s.deliver_vec != VEC_PAGE) &&
              (nested_vector != VEC_PAGE)) begin
            cand_vec = VEC_DOUBLE;
          end
          if ((s.deliver_vec == VEC_PAGE) &&
              (nested_vector != VEC_PAGE)) begin
            cand_vec = VEC_DOUBLE;
          end
        end else if (instr_boundary) begin
          cand_valid = 1'b1;
          if (dbg_trap) begin
            cand_vec = VEC_DEBUG;
          end else if (dbg_exec_break) begin
            cand_vec = VEC_DEBUG;
            cand_dbg_fault = 1'b1;
          end else if (s.nmi_pending && !s.nmi_in_service) begin
            cand_vec = VEC_NMI;
          end else if (irq_sync && s.ctrl.int_enable) begin
            cand_valid = 1'b0;
          end else if (fetch_seg_fault) begin
            cand_vec = fetch_seg_not_present ? VEC_NOT_PRES : VEC_PROT;
          end else if (fetch_page_fault) begin
            cand_vec = VEC_PAGE;
          end else if (illegal_opcode || (prot_only_opcode &&
                       (s.ctrl.real_mode || s.ctrl.v86_mode))) begin
            cand_vec = VEC_OPCODE;
          end else if ((instr_len > MAX_INSTR_BYTES) || priv_violation) begin
            cand_vec = VEC_PROT;
          end else if (wait_opcode && s.ctrl.task_switched_flag &&
                       s.ctrl.monitor_coproc_flag) begin
            cand_vec = VEC_NO_DEV;
          end else if (fpu_opcode && (s.ctrl.fpu_emulation_flag ||
                       s.ctrl.task_switched_flag)) begin
            cand_vec = VEC_NO_DEV;
          end else if (fpu_opcode && fpu_error) begin
            cand_vec = VEC_FPU_ERR;
          end else if (mem_seg_fault) begin
            cand_vec = mem_seg_not_present ? VEC_NOT_PRES :
                       mem_seg_stack ? VEC_STACK : VEC_PROT;
          end else if (mem_page_fault) begin
            cand_vec = VEC_PAGE;
          end else if (exec_exc_valid &&
                       (exec_soft_int || !is_reserved(exec_exc_vector))) begin
            cand_vec = exec_exc_vector;
            cand_trap_src = exec_soft_int;
          end else begin
            cand_valid = 1'b0;
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.out.valid = 1'b0;
    // NMI return ends service and lets a latched request through
    if (interrupt_return_instr) begin
      next_s.nmi_in_service = 1'b0;
    end
    if (delivery_done) begin
      next_s.deliver_busy = 1'b0;
    end
    // Maskable request accepted: start acknowledge, mask further ones
    if (s.state == ST_RUN && !nested_now && instr_boundary &&
        !dbg_trap && !dbg_exec_break &&
        !(s.nmi_pending && !s.nmi_in_service) &&
        irq_sync && s.ctrl.int_enable) begin
      next_s.state = ST_ACK_WAIT;
      next_s.ctrl.int_enable = 1'b0;
    end
    if (s.state == ST_ACK_WAIT && ack_valid) begin
      next_s.state = ST_RUN;
    end
    // Report the selected exception
    if (cand_valid) begin
      next_s.out.valid = 1'b1;
      next_s.out.vector = cand_vec;
      next_s.out.cls = cand_cls;
      next_s.out.restartable = (cand_cls == CLS_FAULT) &&
                               !task_state_segment_partial;
      next_s.deliver_busy = !cand_trap_src &&
                            (cand_vec >= VEC_BAD_TASK) &&
                            (cand_vec <= VEC_PAGE);
      next_s.deliver_vec = cand_vec;
      if (cand_vec == VEC_NMI && cand_cls == CLS_NMI) begin
        next_s.nmi_pending = 1'b0;
        next_s.nmi_in_service = 1'b1;
        next_s.ctrl.int_enable = 1'b0;
      end
    end
    // A new edge always latches, even in the clearing cycle
    if (nmi_edge) begin
      next_s.nmi_pending = 1'b1;
    end
    // Register access: read data captured in setup, write in access
    if (psel && !penable) begin
      next_s.prdata = rd_word;
    end
    if (psel && penable && pwrite && (paddr == CTRL_OFS)) begin
      next_s.ctrl = ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= ctrl_t'(CTRL_RST);
      s.out.cls <= CLS_FAULT;
    end else begin
      s <= next_s;
    end
  end

  // Outputs from registers
  assign exc_valid = s.out.valid;
  assign exc_vector = s.out.vector;
  assign exc_class = s.out.cls;
  assign exc_restartable = s.out.restartable;
  assign inta_req = (s.state == ST_ACK_WAIT);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  irq_boundary_a: assert property (
    $rose(inta_req) |-> $past(instr_boundary) && $past(s.ctrl.int_enable)
      && !s.ctrl.int_enable)
    else $error("acknowledge started off a boundary or while masked");

  nmi_first_a: assert property (
    s.state == ST_RUN && !nested_now && instr_boundary && !dbg_trap &&
    !dbg_exec_break && s.nmi_pending && !s.nmi_in_service
    |=> exc_valid && exc_vector == VEC_NMI && exc_class == CLS_NMI
      && !inta_req && s.nmi_in_service && !s.ctrl.int_enable)
    else $error("NMI not served first or maskable not masked");

  nmi_block_a: assert property (
    s.nmi_in_service && s.nmi_pending && !interrupt_return_instr
    |=> s.nmi_pending && s.nmi_in_service)
    else $error("latched NMI lost or served during NMI service");

  one_report_a: assert property (
    exc_valid |-> $past(instr_boundary || nested_now ||
      (s.state == ST_ACK_WAIT && ack_valid)) ##1 !exc_valid
      || $past(instr_boundary) || $past(nested_fault) || $past(ack_valid))
    else $error("exception reported without a cause");

  page_fault_cls_a: assert property (
    exc_valid && exc_class != CLS_TRAP && exc_vector == VEC_PAGE
    |-> exc_class == CLS_FAULT &&
      exc_restartable == !$past(task_state_segment_partial))
    else $error("page fault not classed as fault");

  abort_cls_a: assert property (
    exc_valid && exc_class == CLS_ABORT
    |-> exc_vector == VEC_DOUBLE && !exc_restartable)
    else $error("abort on wrong vector or marked restartable");

  no_reserved_a: assert property (
    exc_valid && exc_class != CLS_TRAP |-> !is_reserved(exc_vector))
    else $error("reserved vector raised by hardware");

  debug_first_a: assert property (
    s.state == ST_RUN && !nested_now && instr_boundary && dbg_trap
    |=> exc_valid && exc_vector == VEC_DEBUG && exc_class == CLS_TRAP)
    else $error("debug trap not reported first");

  seg_double_a: assert property (
    s.state == ST_RUN && nested_now && s.deliver_vec != VEC_PAGE &&
    nested_vector != VEC_PAGE
    |=> exc_valid && exc_vector == VEC_DOUBLE && !s.deliver_busy)
    else $error("segment delivery failure not escalated");

  page_double_a: assert property (
    s.state == ST_RUN && nested_now && s.deliver_vec == VEC_PAGE
    |=> exc_valid && (exc_vector == VEC_DOUBLE) ==
      $past(nested_vector != VEC_PAGE))
    else $error("page fault delivery escalation wrong");

endmodule // interrupt_exception_prioritizer

/* File: hdl/exc_prio_pkg.sv */
// Shared constants and types for the interrupt and exception prioritizer.
// Assumes a single 200 MHz core clock and a 32-bit APB register port.
package exc_prio_pkg;

  // ----------------------------------------------------------------
  // Vector numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_DIVIDE = 8'h00;
  localparam logic [7:0] VEC_DEBUG = 8'h01;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_BOUND = 8'h05;
  localparam logic [7:0] VEC_OPCODE = 8'h06;
  localparam logic [7:0] VEC_NO_DEV = 8'h07;
  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_BAD_TASK = 8'h0a;
  localparam logic [7:0] VEC_NOT_PRES = 8'h0b;
  localparam logic [7:0] VEC_STACK = 8'h0c;
  localparam logic [7:0] VEC_PROT = 8'h0d;
  localparam logic [7:0] VEC_PAGE = 8'h0e;
  localparam logic [7:0] VEC_FPU_ERR = 8'h10;
  localparam logic [7:0] VEC_ALIGN = 8'h11;
  localparam logic [7:0] VEC_RSV_LO = 8'h12;
  localparam logic [7:0] VEC_RSV_HI = 8'h1f;
  localparam logic [7:0] VEC_RSV_A = 8'h09;
  localparam logic [7:0] VEC_RSV_B = 8'h0f;

  // Longest legal instruction in bytes
  localparam logic [4:0] MAX_INSTR_BYTES = 5'h0f;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [5:0] CTRL_RST = 6'h10;
  localparam int STAT_VEC_LSB = 0;
  localparam int STAT_CLS_LSB = 8;
  localparam int STAT_RST_BIT = 10;
  localparam int STAT_NMIP_BIT = 16;
  localparam int STAT_NMIS_BIT = 17;
  localparam int STAT_ACK_BIT = 18;
  localparam int STAT_BUSY_BIT = 19;

  // Exception class
  typedef enum logic [1:0] {CLS_FAULT, CLS_TRAP, CLS_ABORT, CLS_NMI} exc_class_t;

  // Control word, bit 0 first from the right
  typedef struct packed {
    logic v86_mode;
    logic real_mode;
    logic fpu_emulation_flag;
    logic monitor_coproc_flag;
    logic task_switched_flag;
    logic int_enable;
  } ctrl_t;

  // Reported exception
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
    exc_class_t cls;
    logic restartable;
  } exc_out_t;

  // Reserved vectors that hardware never raises
  function automatic logic is_reserved(input logic [7:0] v);
    return (v == VEC_RSV_A) || (v == VEC_RSV_B) ||
           ((v >= VEC_RSV_LO) && (v <= VEC_RSV_HI));
  endfunction

endpackage

/* File: hdl/ext_req_sampler.sv */
// Synchronises the two external interrupt request pins.
// Assumes the pins are asynchronous to pclk.
`timescale 1ns/1ps
module ext_req_sampler
  import exc_prio_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins
  input wire logic nmi_request,
  input wire logic maskable_irq_request,
  // Synchronised view
  output logic nmi_edge,
  output logic irq_sync
);

  typedef struct packed {
    logic nmi_s1;
    logic nmi_s2;
    logic nmi_s3;
    logic irq_s1;
    logic irq_s2;
  } samp_state_t;

  samp_state_t s;
  samp_state_t next_s;

  // Two-stage synchronisers, third stage only for the edge
  always_comb begin
    next_s = s;
    next_s.nmi_s1 = nmi_request;
    next_s.nmi_s2 = s.nmi_s1;
    next_s.nmi_s3 = s.nmi_s2;
    next_s.irq_s1 = maskable_irq_request;
    next_s.irq_s2 = s.irq_s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Rising edge of the synchronised request
  assign nmi_edge = s.nmi_s2 & ~s.nmi_s3;
  assign irq_sync = s.irq_s2;

endmodule // ext_req_sampler

/* File: hdl/vector_classifier.sv */
// Maps a vector to its fault, trap, abort or NMI class.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module vector_classifier
  import exc_prio_pkg::*;
(
  // Candidate vector
  input wire logic [7:0] vector,
  input wire logic debug_fault,
  input wire logic trap_source,
  // Result
  output exc_class_t cls
);

  // Class decode
  always_comb begin
    cls = CLS_TRAP;
    if (!trap_source) begin
      unique case (vector)
        VEC_DIVIDE, VEC_BOUND, VEC_OPCODE, VEC_NO_DEV,
        VEC_BAD_TASK, VEC_NOT_PRES, VEC_STACK, VEC_PROT,
        VEC_PAGE, VEC_FPU_ERR, VEC_ALIGN: cls = CLS_FAULT;
        VEC_DEBUG: cls = debug_fault ? CLS_FAULT : CLS_TRAP;
        VEC_NMI: cls = CLS_NMI;
        VEC_DOUBLE: cls = CLS_ABORT;
        default: cls = CLS_TRAP;
      endcase
    end
  end

endmodule // vector_classifier

/* File: verification/irq_ctrl_model.sv */
// Behavioural model of the external interrupt controller.
// Assumes the bench sets request levels, vector and answer delay.
`timescale 1ns/1ps
module irq_ctrl_model
  import exc_prio_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Bench controls
  input wire logic nmi_level,
  input wire logic irq_level,
  input wire logic [7:0] vec,
  input wire logic [3:0] delay,
  // Device side
  input wire logic inta_req,
  output logic nmi_request,
  output logic maskable_irq_request,
  output logic ack_valid,
  output logic [7:0] ack_vector
);
  // ------------------------------------------------------------
  // Request pins and acknowledge answer
  // ------------------------------------------------------------
  logic [3:0] cnt;
  logic acked;
  logic fire;
  initial begin
    cnt = 4'h0;
    acked = 1'b0;
    ack_valid = 1'b0;
    ack_vector = 8'h5a;
  end
  // Maskable line drops once its vector has been handed over
  assign nmi_request = nmi_level;
  assign maskable_irq_request = irq_level & ~acked;
  assign fire = inta_req && !ack_valid && cnt == delay;
  // Vector bus toggles when idle so a stale value never passes
  always @(posedge pclk) begin
    cnt <= (inta_req && !ack_valid) ? cnt + 4'h1 : 4'h0;
    ack_valid <= fire;
    ack_vector <= fire ? vec : ~ack_vector;
    acked <= irq_level & (acked | ack_valid);
  end
endmodule // irq_ctrl_model

/* File: verification/interrupt_exception_prioritizer_tb_top.sv */
// Self-checking bench for the interrupt and exception prioritizer.
// Assumes a 200 MHz pclk and the controller model beside the block.
`timescale 1ns/1ps
module interrupt_exception_prioritizer_tb_top
  import exc_prio_pkg::*;
;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, inta_req, ack_valid, nmi_request;
  logic maskable_irq_request, exc_valid, exc_restartable;
  logic nmi_level = 0, irq_level = 0, instr_boundary = 0, ret_instr = 0;
  logic nested_fault = 0, delivery_done = 0;
  logic [7:0] vec = '0, xv = '0, nv = '0, ack_vector, exc_vector;
  logic [3:0] delay = '0;
  logic [4:0] len = 5'h01;
  logic [17:0] c = '0;
  exc_class_t exc_class;
  int fails = 0, checks_done = 0;

  irq_ctrl_model i_irq_ctrl_model (.pclk, .nmi_level, .irq_level, .vec,
    .delay, .inta_req, .nmi_request, .maskable_irq_request, .ack_valid,
    .ack_vector);

  interrupt_exception_prioritizer i_interrupt_exception_prioritizer (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .nmi_request, .maskable_irq_request, .inta_req,
    .ack_valid, .ack_vector, .instr_boundary,
    .interrupt_return_instr(ret_instr), .dbg_trap(c[0]),
    .dbg_exec_break(c[1]), .fetch_seg_fault(c[2]),
    .fetch_seg_not_present(c[3]), .fetch_page_fault(c[4]),
    .illegal_opcode(c[5]), .prot_only_opcode(c[6]), .instr_len(len),
    .priv_violation(c[7]), .wait_opcode(c[8]), .fpu_opcode(c[9]),
    .fpu_error(c[10]), .mem_seg_fault(c[11]),
    .mem_seg_not_present(c[12]), .mem_seg_stack(c[13]),
    .mem_page_fault(c[14]), .exec_exc_valid(c[15]), .exec_exc_vector(xv),
    .exec_soft_int(c[16]), .task_state_segment_partial(c[17]),
    .nested_fault, .nested_vector(nv), .delivery_done, .exc_valid,
    .exc_vector, .exc_class, .exc_restartable);

  // Clock generator
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task cmp(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %0h exp %0h", $time, s, got, exp);
    end
  endtask

  // One APB transfer; waits for pready at each access edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // One boundary with check set k; report expected one cycle later
  task bnd(input logic [17:0] k, input logic v, input logic [7:0] ev,
           input exc_class_t ec);
    @(posedge pclk);
    c <= k; instr_boundary <= 1;
    @(posedge pclk);
    c <= '0; instr_boundary <= 0;
    #1 cmp(exc_valid, v, "valid");
    if (v) begin
      cmp(exc_vector, ev, "vector");
      cmp(exc_class, ec, "class");
      cmp(exc_restartable, ec == CLS_FAULT && !k[17], "restart");
    end
    @(posedge pclk);
    #1 cmp(exc_valid, 0, "single pulse");
  endtask

  // Exception met while delivering the current one
  // Vector and class stand from the last report when none is expected
  task nest(input logic e, input logic [7:0] v, input logic [7:0] ev,
            input exc_class_t ec);
    @(posedge pclk);
    nested_fault <= 1; nv <= v;
    @(posedge pclk);
    nested_fault <= 0;
    #1 cmp(exc_valid, e, "nest valid");
    cmp(exc_vector, ev, "nest vector");
    cmp(exc_class, ec, "nest class");
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task regs();
    apb(0, CTRL_OFS, 0);
    cmp(rd, 32'h0000_0010, "ctrl reset");
    apb(1, CTRL_OFS, 32'hffff_ffff);
    apb(0, CTRL_OFS, 0);
    cmp(rd, 32'h0000_003f, "ctrl bits");
    apb(1, CTRL_OFS, 32'h0000_0010);
    apb(0, 12'h008, 0);
    cmp({rd[0], err}, 2'b01, "unmapped");
  endtask

  task prio();
    bnd(18'h0_0017, 1, 8'h01, CLS_TRAP);
    bnd(18'h0_0016, 1, 8'h01, CLS_FAULT);
    bnd(18'h0_0014, 1, 8'h0d, CLS_FAULT);
    bnd(18'h0_001c, 1, 8'h0b, CLS_FAULT);
    bnd(18'h0_0030, 1, 8'h0e, CLS_FAULT);
    bnd(18'h0_0140, 1, 8'h06, CLS_FAULT);
    bnd(18'h0_0080, 1, 8'h0d, CLS_FAULT);
    len <= 5'h10;
    bnd(18'h0_0000, 1, 8'h0d, CLS_FAULT);
    len <= 5'h0f;
    bnd(18'h0_0000, 0, 8'h00, CLS_FAULT);
    apb(1, CTRL_OFS, 32'h0000_0016);
    bnd(18'h0_0100, 1, 8'h07, CLS_FAULT);
    apb(1, CTRL_OFS, 32'h0000_0014);
    bnd(18'h0_0100, 0, 8'h00, CLS_FAULT);
    bnd(18'h0_0200, 0, 8'h00, CLS_FAULT);
    apb(1, CTRL_OFS, 32'h0000_0018);
    bnd(18'h0_0600, 1, 8'h07, CLS_FAULT);
    apb(1, CTRL_OFS, 32'h0000_0010);
    bnd(18'h0_0600, 1, 8'h10, CLS_FAULT);
    bnd(18'h0_6800, 1, 8'h0c, CLS_FAULT);
    bnd(18'h0_5800, 1, 8'h0b, CLS_FAULT);
    bnd(18'h0_4000, 1, 8'h0e, CLS_FAULT);
    xv <= 8'h11;
    bnd(18'h0_8000, 1, 8'h11, CLS_FAULT);
    xv <= 8'h0f;
    bnd(18'h0_8000, 0, 8'h00, CLS_FAULT);
    bnd(18'h1_8000, 1, 8'h0f, CLS_TRAP);
    xv <= 8'h04;
    bnd(18'h0_8000, 1, 8'h04, CLS_TRAP);
    xv <= 8'h0a;
    bnd(18'h2_8000, 1, 8'h0a, CLS_FAULT);
  endtask

  task dbl();
    bnd(18'h0_0014, 1, 8'h0d, CLS_FAULT);
    nest(1, 8'h0b, 8'h08, CLS_ABORT);
    bnd(18'h0_4000, 1, 8'h0e, CLS_FAULT);
    nest(1, 8'h0e, 8'h0e, CLS_FAULT);
    nest(1, 8'h0d, 8'h08, CLS_ABORT);
    bnd(18'h0_0014, 1, 8'h0d, CLS_FAULT);
    @(posedge pclk) delivery_done <= 1;
    @(posedge pclk) delivery_done <= 0;
    nest(0, 8'h0b, 8'h0d, CLS_FAULT);
  endtask

  task nmi();
    apb(1, CTRL_OFS, 32'h0000_0011);
    irq_level <= 1; nmi_level <= 1;
    repeat (5) @(posedge pclk);
    bnd(18'h0_0002, 1, 8'h01, CLS_FAULT);
    bnd(18'h0_0004, 1, 8'h02, CLS_NMI);
    bnd(18'h0_0000, 0, 8'h00, CLS_FAULT);
    cmp(inta_req, 0, "masked");
    nmi_level <= 0;
    repeat (4) @(posedge pclk);
    nmi_level <= 1;
    irq_level <= 0;
    repeat (5) @(posedge pclk);
    bnd(18'h0_0000, 0, 8'h00, CLS_FAULT);
    apb(0, STATUS_OFS, 0);
    cmp(rd[STAT_NMIS_BIT:STAT_NMIP_BIT], 2'b11, "nmi status");
    @(posedge pclk) ret_instr <= 1;
    @(posedge pclk) ret_instr <= 0;
    bnd(18'h0_0000, 1, 8'h02, CLS_NMI);
  endtask

  task mask_irq(input logic [7:0] v, input logic [3:0] d);
    int n;
    apb(1, CTRL_OFS, 32'h0000_0011);
    irq_level <= 1; vec <= v; delay <= d;
    repeat (5) @(posedge pclk);
    #1 cmp(inta_req, 0, "no boundary");
    bnd(18'h0_0000, 0, 8'h00, CLS_FAULT);
    cmp(inta_req, 1, "ack wait");
    n = 0;
    while (exc_valid !== 1'b1 && n < 50) begin
      @(posedge pclk);
      #1 n++;
    end
    cmp(n < 50, 1, "ack answer");
    cmp(exc_vector, v, "irq vector");
    cmp({exc_class, inta_req}, {CLS_TRAP, 1'b0}, "irq class");
    irq_level <= 0;
  endtask

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #(20000 * 5);
    fails++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    regs();
    prio();
    dbl();
    nmi();
    mask_irq(8'h40, 4'h0);
    mask_irq(8'hff, 4'h6);
    summarize();
  end
endmodule // interrupt_exception_prioritizer_tb_top
